// File: two_wire_pkg.sv
// Constants for the two-wire serial master: register map, fields, timing
package two_wire_pkg;
  // Register addresses on the special function register bus
  localparam logic [7:0] SHARED_TRANSMIT_BUFFER_ADDR = 8'h9a;
  localparam logic [7:0] SHARED_RECEIVE_BUFFER_ADDR = 8'h9b;
  localparam logic [7:0] TWO_WIRE_MODE_REGISTER_ADDR = 8'he8;
  localparam logic [7:0] SLAVE_ADDRESS_REGISTER_ADDR = 8'he9;
  localparam logic [7:0] TWO_WIRE_INTERRUPT_STATUS_ADDR = 8'hea;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Mode register fields
  localparam int INTERFACE_ENABLE_BIT = 7;
  localparam int RATE_LSB = 5;
  localparam int RATE_MSB = 6;
  localparam int RECEIVE_BYTE_COUNT_MSB = 4;
  // Slave address register fields
  localparam int TRANSFER_DIRECTION_BIT = 0;
  // Status register fields
  localparam int BUS_IN_USE_BIT = 7;
  localparam int MISSING_ACK_BIT = 6;
  localparam int RECEIVE_NOT_EMPTY_BIT = 5;
  localparam int TRANSMIT_EMPTY_BIT = 4;
  localparam int FILL_LEVEL_MSB = 3;
  localparam int FILL_LEVEL_LSB = 2;
  localparam int SIMULTANEOUS_ACCESS_BIT = 1;
  localparam int TRANSMIT_OVERFLOW_BIT = 0;
  // Fill level encodings
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_HALF = 2'h2;
  localparam logic [1:0] FILL_FULL = 2'h3;
  // One bit is 16 core cycles base, split in 4 quarters; the SCL-high wait makes it 20 at the fastest rate
  localparam int BIT_CYCLES_BASE = 16;
  localparam int QUARTERS_PER_BIT = 4;
  localparam logic [5:0] QUARTER_BASE = 6'(BIT_CYCLES_BASE / QUARTERS_PER_BIT);
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Default FIFO depth
  localparam int FIFO_DEPTH_DEFAULT = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BIT = 3'b011,
    ST_ACK = 3'b010,
    ST_STOP = 3'b110
  } engine_state_type;
endpackage

// File: two_wire_master.sv
// Two-wire serial master: registers, FIFOs, status flags and bus sequencing
//
// What this block does
// - Busy flag in status bit 7 while in use; transmit FIFO drains.
// - Missing slave acknowledge sets bit 6 and stops communication.
// - Receive flag bit 5 set whenever receive FIFO holds a byte.
// - Transmit flag bit 4 set when transmit FIFO becomes empty.
// - Bits 3:2 show fill of active FIFO: 00 empty, 10 half, 11 full.
// - Simultaneous write and read sets access error bit 1.
// - Writing a byte into a full transmit FIFO sets bit 0.
// - Writing zero to a flag bit in 6:4 or 1:0 clears it.
// - Address register LSB selects read or write transfer.
// - Master acknowledges every received byte but the final one automatically.
// - Final received byte gets an automatic not-acknowledge.
// - Address rewrite during transfer gives repeated start, not stop.
// - Address write (address 7:1, direction 0) starts a transfer.
// - Reads stop after receive count plus one bytes, or on error.
// - Transfers start only while interface enable bit 7 is set.
// - Error during a write flushes transmit FIFO and terminates.
`timescale 1ns/1ps
module two_wire_master #(
  parameter int FIFO_DEPTH = two_wire_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_q,
  input wire logic scl_in,
  output logic scl_out_q,
  output logic scl_oe_n_q,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_n_q,
  output logic irq_q
);
  import two_wire_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  logic [7:0] mode_q;
  logic [7:0] addr_q;
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [CW-1:0] tx_cnt_q, rx_cnt_q;
  logic missing_ack_flag_q, receive_not_empty_flag_q, transmit_empty_flag_q;
  logic simultaneous_access_error_q, transmit_overflow_error_q;
  logic [2:0] s1_q, s2_q, s3_q;
  logic scl_hi_q, sda_hi_q;
  engine_state_type state_q;
  logic [1:0] ph_q;
  logic [2:0] bitn_q;
  logic [7:0] shift_q;
  logic [5:0] div_q;
  logic [5:0] rx_taken_q;
  logic bus_in_use_flag_q, pend_q, rd_active_q, addr_ph_q, ack_q;

  logic wr_tx, rd_rx, wr_mode, wr_addr, wr_stat;
  logic tx_full, rx_full, tx_push, tx_pop, tx_flush, rx_push, rx_pop;
  logic tick, go, ack_end, rd_data, nack_err, last_rx, rx_done;
  logic [5:0] quarter_len;
  logic [4:0] rct;
  logic [1:0] fifo_fill_level;
  logic [CW-1:0] active_cnt;

  assign wr_tx = sfr_wr && sfr_addr == SHARED_TRANSMIT_BUFFER_ADDR;
  assign rd_rx = sfr_rd && sfr_addr == SHARED_RECEIVE_BUFFER_ADDR;
  assign wr_mode = sfr_wr && sfr_addr == TWO_WIRE_MODE_REGISTER_ADDR;
  assign wr_addr = sfr_wr && sfr_addr == SLAVE_ADDRESS_REGISTER_ADDR;
  assign wr_stat = sfr_wr && sfr_addr == TWO_WIRE_INTERRUPT_STATUS_ADDR;
  assign rct = mode_q[RECEIVE_BYTE_COUNT_MSB:0];

  assign tx_full = tx_cnt_q == FULL_COUNT;
  assign rx_full = rx_cnt_q == FULL_COUNT;
  assign tx_push = wr_tx && !tx_full;
  assign rx_pop = rd_rx && rx_cnt_q != '0;

  // Quarter-bit tick every 4 * 2^rate core cycles; bit time is 16 * 2^rate core cycles, 20 at rate 0
  assign quarter_len = QUARTER_BASE << mode_q[RATE_MSB:RATE_LSB];
  assign tick = state_q != ST_IDLE && div_q == quarter_len - 6'h01;
  // Slave may stretch the clock: the quarter after the release waits for
  // SCL seen high; waiting on the release quarter itself would deadlock
  assign go = tick && !(ph_q == 2'h2 && !scl_hi_q);
  assign ack_end = state_q == ST_ACK && ph_q == 2'h3 && go;
  assign rd_data = rd_active_q && !addr_ph_q;
  assign last_rx = rx_taken_q == {1'b0, rct};
  assign rx_done = rx_taken_q == 6'({1'b0, rct}) + 6'h01;
  assign nack_err = ack_end && !rd_data && ack_q;
  // Busy drains the transmit FIFO byte by byte into the shift register
  assign tx_pop = ack_end && !nack_err && !rd_active_q
                  && tx_cnt_q != '0;
  assign tx_flush = nack_err && !rd_active_q;
  assign rx_push = state_q == ST_ACK && ph_q == 2'h2 && go && rd_data
                   && !rx_full;

  // Input pins pass three flops; a level counts once stages 2 and 3 agree
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      scl_hi_q <= 1'b1;
      sda_hi_q <= 1'b1;
    end else begin
      s1_q <= {1'b0, scl_in, sda_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q[1] == s3_q[1]) begin
        scl_hi_q <= s3_q[1];
      end
      if (s2_q[0] == s3_q[0]) begin
        sda_hi_q <= s3_q[0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= MODE_RESET;
      addr_q <= ADDRESS_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= sfr_wdata;
      end
      if (wr_addr) begin
        addr_q <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else if (tx_flush) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_q] <= sfr_wdata;
        tx_wp_q <= tx_wp_q + PW'(1);
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + PW'(1);
      end
      tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
    end
  end

  // A full receive FIFO drops the byte; firmware must keep up
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= shift_q;
        rx_wp_q <= rx_wp_q + PW'(1);
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + PW'(1);
      end
      rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || state_q == ST_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      ph_q <= '0;
      bitn_q <= '0;
      shift_q <= '0;
      bus_in_use_flag_q <= 1'b0;
      pend_q <= 1'b0;
      rd_active_q <= 1'b0;
      addr_ph_q <= 1'b0;
      ack_q <= 1'b0;
      rx_taken_q <= '0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (wr_addr && mode_q[INTERFACE_ENABLE_BIT]) begin
        if (state_q == ST_IDLE) begin
          state_q <= ST_START;
          ph_q <= '0;
          bus_in_use_flag_q <= 1'b1;
        end else begin
          pend_q <= 1'b1;
        end
      end
      if (go) begin
        ph_q <= ph_q + 2'h1;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (pend_q) begin
            pend_q <= 1'b0;
            state_q <= ST_START;
            ph_q <= '0;
            bus_in_use_flag_q <= 1'b1;
          end
        end
        ST_START: begin
          // Also serves as repeated start, entered with SCL low
          if (go) begin
            unique case (ph_q)
              2'h0: sda_oe_n_q <= 1'b1;
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: sda_oe_n_q <= 1'b0;
              2'h3: begin
                scl_oe_n_q <= 1'b0;
                shift_q <= addr_q;
                rd_active_q <= addr_q[TRANSFER_DIRECTION_BIT];
                addr_ph_q <= 1'b1;
                rx_taken_q <= '0;
                bitn_q <= '0;
                state_q <= ST_BIT;
              end
            endcase
          end
        end
        ST_BIT: begin
          if (go) begin
            unique case (ph_q)
              2'h0: sda_oe_n_q <= rd_data ? 1'b1 : shift_q[7];
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: shift_q <= {shift_q[6:0], sda_hi_q};
              2'h3: begin
                scl_oe_n_q <= 1'b0;
                bitn_q <= bitn_q + 3'h1;
                if (bitn_q == LAST_BIT) begin
                  state_q <= ST_ACK;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (go) begin
            unique case (ph_q)
              2'h0: begin
                // Ack every byte but the last, which gets a not-ack
                sda_oe_n_q <= rd_data ? last_rx : 1'b1;
              end
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: begin
                ack_q <= sda_hi_q;
                if (rd_data) begin
                  rx_taken_q <= rx_taken_q + 6'h01;
                end
              end
              2'h3: begin
                // SDA stays put here; releasing it with SCL falling races
                // into a false stop at the slaves
                scl_oe_n_q <= 1'b0;
                addr_ph_q <= 1'b0;
                bitn_q <= '0;
                if (nack_err) begin
                  state_q <= ST_STOP;
                end else if (rd_active_q && (addr_ph_q || !rx_done)) begin
                  state_q <= ST_BIT;
                end else if (tx_pop) begin
                  shift_q <= tx_mem[tx_rp_q];
                  state_q <= ST_BIT;
                end else if (pend_q) begin
                  // A rewrite in this very cycle stays pending
                  pend_q <= wr_addr && mode_q[INTERFACE_ENABLE_BIT];
                  state_q <= ST_START;
                end else begin
                  state_q <= ST_STOP;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (go) begin
            unique case (ph_q)
              2'h0: sda_oe_n_q <= 1'b0;
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: sda_oe_n_q <= 1'b1;
              2'h3: begin
                bus_in_use_flag_q <= 1'b0;
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_sys) begin
    scl_out_q <= 1'b0;
    sda_out_q <= 1'b0;
  end

  // Flags: a set in the same cycle as a software clear wins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      missing_ack_flag_q <= STATUS_RESET[MISSING_ACK_BIT];
      receive_not_empty_flag_q <= STATUS_RESET[RECEIVE_NOT_EMPTY_BIT];
      transmit_empty_flag_q <= STATUS_RESET[TRANSMIT_EMPTY_BIT];
      simultaneous_access_error_q <= STATUS_RESET[SIMULTANEOUS_ACCESS_BIT];
      transmit_overflow_error_q <= STATUS_RESET[TRANSMIT_OVERFLOW_BIT];
    end else begin
      if (nack_err) begin
        missing_ack_flag_q <= 1'b1;
      end else if (wr_stat && !sfr_wdata[MISSING_ACK_BIT]) begin
        missing_ack_flag_q <= 1'b0;
      end
      if (rx_cnt_q != '0) begin
        receive_not_empty_flag_q <= 1'b1;
      end else if (wr_stat && !sfr_wdata[RECEIVE_NOT_EMPTY_BIT]) begin
        receive_not_empty_flag_q <= 1'b0;
      end
      if ((tx_pop && tx_cnt_q == CW'(1) && !tx_push)
          || (tx_flush && tx_cnt_q != '0)) begin
        transmit_empty_flag_q <= 1'b1;
      end else if (wr_stat && !sfr_wdata[TRANSMIT_EMPTY_BIT]) begin
        transmit_empty_flag_q <= 1'b0;
      end
      if (sfr_wr && sfr_rd) begin
        simultaneous_access_error_q <= 1'b1;
      end else if (wr_stat && !sfr_wdata[SIMULTANEOUS_ACCESS_BIT]) begin
        simultaneous_access_error_q <= 1'b0;
      end
      if (wr_tx && tx_full) begin
        transmit_overflow_error_q <= 1'b1;
      end else if (wr_stat && !sfr_wdata[TRANSMIT_OVERFLOW_BIT]) begin
        transmit_overflow_error_q <= 1'b0;
      end
    end
  end

  // Only one FIFO is active at a time, chosen by the transfer direction
  always_comb begin
    active_cnt = rd_active_q ? rx_cnt_q : tx_cnt_q;
    if (active_cnt == '0) begin
      fifo_fill_level = FILL_EMPTY;
    end else if (active_cnt == FULL_COUNT) begin
      fifo_fill_level = FILL_FULL;
    end else begin
      fifo_fill_level = FILL_HALF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= missing_ack_flag_q || receive_not_empty_flag_q
               || transmit_empty_flag_q;
    end
  end

  // Read data is captured on the read strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sfr_rdata_q <= '0;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        SHARED_RECEIVE_BUFFER_ADDR: begin
          sfr_rdata_q <= rx_cnt_q != '0 ? rx_mem[rx_rp_q] : 8'h00;
        end
        TWO_WIRE_MODE_REGISTER_ADDR: sfr_rdata_q <= mode_q;
        SLAVE_ADDRESS_REGISTER_ADDR: sfr_rdata_q <= addr_q;
        TWO_WIRE_INTERRUPT_STATUS_ADDR: begin
          sfr_rdata_q <= {bus_in_use_flag_q, missing_ack_flag_q,
                          receive_not_empty_flag_q, transmit_empty_flag_q,
                          fifo_fill_level, simultaneous_access_error_q,
                          transmit_overflow_error_q};
        end
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end
endmodule

// File: two_wire_master_assertions.sv
// Checker for the two-wire master status and sequencing ports
`timescale 1ns/1ps
module two_wire_master_assertions #(
  parameter int FIFO_DEPTH = two_wire_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic scl_in,
  input wire logic scl_out_q,
  input wire logic scl_oe_n_q,
  input wire logic sda_in,
  input wire logic sda_out_q,
  input wire logic sda_oe_n_q,
  input wire logic irq_q
);
  import two_wire_pkg::*;
  localparam logic [7:0] ST = TWO_WIRE_INTERRUPT_STATUS_ADDR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic en_q;
  logic [3:0] rel_q;
  logic st_rd;
  logic idle;
  assign st_rd = sfr_rd && !sfr_wr && sfr_addr == ST;
  assign idle = scl_oe_n_q && sda_oe_n_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) en_q <= 1'b0;
    else if (sfr_wr && sfr_addr == TWO_WIRE_MODE_REGISTER_ADDR)
      en_q <= sfr_wdata[INTERFACE_ENABLE_BIT];
  end
  // Runs of both lines released; inside a frame at rate 0, without stretching, they stay under 13
  always_ff @(posedge clk_sys) begin
    if (!rstn || !idle) rel_q <= 4'h0;
    else if (rel_q != 4'hf) rel_q <= rel_q + 4'h1;
  end
  property p_irq; st_rd |=> irq_q == |sfr_rdata_q[6:4]; endproperty
  a_irq: assert property (p_irq)
    else $error("irq differs from status flags");
  property p_fill; st_rd |=> sfr_rdata_q[3:2] != 2'h1; endproperty
  a_fill: assert property (p_fill)
    else $error("reserved fill code");
  property p_busy; st_rd && !idle |=> sfr_rdata_q[7]; endproperty
  a_busy: assert property (p_busy)
    else $error("lines driven while not busy");
  property p_idle; st_rd ##1 !sfr_rdata_q[7] |-> idle; endproperty
  a_idle: assert property (p_idle)
    else $error("lines held after busy cleared");
  property p_en; $fell(sda_oe_n_q) || $fell(scl_oe_n_q) |-> en_q; endproperty
  a_en: assert property (p_en)
    else $error("bus driven while disabled");
  property p_start;
    sfr_wr && sfr_addr == SLAVE_ADDRESS_REGISTER_ADDR && en_q && rel_q == 4'hf
      |-> ##[1:20] ($fell(sda_oe_n_q) && scl_oe_n_q);
  endproperty
  a_start: assert property (p_start)
    else $error("no start after address write");
  property p_clear;
    (sfr_wr && !sfr_rd && sfr_addr == ST && sfr_wdata == 8'h00) ##[1:2] st_rd
      |=> sfr_rdata_q[1:0] == 2'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("error flags not cleared");
  property p_acc; (sfr_wr && sfr_rd) ##[1:4] st_rd |=> sfr_rdata_q[1]; endproperty
  a_acc: assert property (p_acc)
    else $error("access error flag missing");
endmodule
bind two_wire_master two_wire_master_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
  .scl_in(scl_in), .scl_out_q(scl_out_q), .scl_oe_n_q(scl_oe_n_q),
  .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
  .irq_q(irq_q));

// File: two_wire_slave_model.sv
// Behavioural two-wire slave answering the master on the shared wires
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [6:0] SLAVE_ID = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic stretch_en,
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] sr = 8'h00;
  logic [7:0] tx = 8'hc3;
  logic act = 1'b0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  int n_start = 0;
  int n_stop = 0;
  int n_mack = 0;
  int n_mnack = 0;
  logic [7:0] got[$];
  initial sda_pull = 1'b0;
  initial scl_pull = 1'b0;
  // Start or repeated start restarts address decode
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      adr = 1'b1;
      n = 0;
      n_start++;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b0;
      n_stop++;
    end
  end
  always @(posedge scl) begin
    if (act) begin
      if (n < 8) sr = {sr[6:0], sda};
      else if (adr) adr = 1'b0;
      else if (rd) begin
        if (sda) n_mnack++;
        else n_mack++;
        tx = tx + 8'h01;
        // Master nack ends the read; release so the stop can form
        if (sda) act = 1'b0;
      end
      n = (n == 8) ? 0 : n + 1;
    end
  end
  always @(negedge scl) begin
    if (act) begin
      sda_pull <= 1'b0;
      if (n == 8 && adr) begin
        rd = sr[0];
        if (sr[7:1] == SLAVE_ID && ack_en) sda_pull <= 1'b1;
        else act = 1'b0;
      end else if (n == 8 && !rd) begin
        got.push_back(sr);
        sda_pull <= ack_en;
      end else if (n < 8 && rd && !adr) sda_pull <= !tx[7 - n];
    end
  end
  // Slow slave: holds the clock low after each byte, before the acknowledge clock
  always @(negedge scl) begin
    if (act && stretch_en && n == 8) begin
      scl_pull = 1'b1;
      #400 scl_pull = 1'b0;
    end
  end
endmodule

// File: i2c_master_status_and_sequencing_tb.sv
// Self-checking bench for the two-wire master status and sequencing
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module i2c_master_status_and_sequencing_tb;
  import two_wire_pkg::*;
  localparam logic [7:0] ST = TWO_WIRE_INTERRUPT_STATUS_ADDR;
  localparam logic [7:0] AD = SLAVE_ADDRESS_REGISTER_ADDR;
  localparam logic [7:0] MD = TWO_WIRE_MODE_REGISTER_ADDR;
  localparam logic [7:0] TX = SHARED_TRANSMIT_BUFFER_ADDR;
  localparam logic [7:0] RX = SHARED_RECEIVE_BUFFER_ADDR;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ack_en = 1'b1;
  logic stretch_en = 1'b0;
  logic [7:0] sfr_rdata_q;
  logic scl_out_q, scl_oe_n_q, sda_out_q, sda_oe_n_q, irq_q;
  logic sda_pull, scl_pull;
  logic [7:0] v;
  int fails = 0;
  int n_checks = 0;
  int s, p;
  // Open drain with pull-ups: any party pulling low wins
  wire logic scl = (scl_oe_n_q | scl_out_q) & ~scl_pull;
  wire logic sda = (sda_oe_n_q | sda_out_q) & ~sda_pull;
  always #12.5 clk_sys = ~clk_sys;
  two_wire_master u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .scl_in(scl),
    .scl_out_q(scl_out_q), .scl_oe_n_q(scl_oe_n_q), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .irq_q(irq_q));
  two_wire_slave_model u_slave (.scl(scl), .sda(sda), .ack_en(ack_en),
    .stretch_en(stretch_en), .sda_pull(sda_pull), .scl_pull(scl_pull));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata_q;
  endtask
  task automatic st(input logic [7:0] e, input string nm);
    rd(ST, v);
    `CHK(nm, e, v)
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 1000; i++) begin
      rd(ST, v);
      if (v[BUS_IN_USE_BIT] === 1'b0) break;
    end
    `CHK("idle wait", 1'b1, i < 1000)
  endtask
  task automatic t_reset();
    s = u_slave.n_start;
    st(STATUS_RESET, "status reset");
    `CHK("irq reset", 1'b0, irq_q)
    rd(MD, v);
    `CHK("mode reset", MODE_RESET, v)
    rd(AD, v);
    `CHK("addr reset", ADDRESS_RESET, v)
    rd(8'h55, v);
    `CHK("unmapped", 8'h00, v)
    wr(AD, 8'ha0);
    repeat (40) @(posedge clk_sys);
    `CHK("start while off", s, u_slave.n_start)
    st(8'h00, "busy while off");
  endtask
  task automatic t_write();
    u_slave.got.delete();
    wr(MD, 8'h80);
    wr(TX, 8'h3c);
    wr(TX, 8'ha5);
    st(8'h08, "tx half");
    wr(AD, 8'ha0);
    rd(ST, v);
    `CHK("busy", 1'b1, v[BUS_IN_USE_BIT])
    idle();
    `CHK("byte0", 8'h3c, u_slave.got[0])
    `CHK("byte1", 8'ha5, u_slave.got[1])
    st(8'h10, "tx empty");
    `CHK("irq", 1'b1, irq_q)
    wr(ST, 8'h00);
    st(8'h00, "cleared");
    `CHK("irq off", 1'b0, irq_q)
  endtask
  task automatic t_error();
    repeat (4) wr(TX, 8'h11);
    st(8'h0c, "tx full");
    wr(TX, 8'h22);
    st(8'h0d, "overflow");
    @(posedge clk_sys);
    sfr_addr <= MD;
    sfr_wdata <= 8'h80;
    sfr_wr <= 1'b1;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    st(8'h0f, "both strobes");
    ack_en <= 1'b0;
    p = u_slave.n_stop;
    wr(AD, 8'ha0);
    idle();
    ack_en <= 1'b1;
    st(8'h53, "nack flush");
    `CHK("stopped", p + 1, u_slave.n_stop)
    wr(ST, 8'h00);
  endtask
  task automatic t_read();
    s = u_slave.n_mack;
    p = u_slave.n_mnack;
    wr(MD, 8'h82);
    stretch_en <= 1'b1;
    wr(AD, 8'ha1);
    idle();
    stretch_en <= 1'b0;
    `CHK("master acks", s + 2, u_slave.n_mack)
    `CHK("final nack", p + 1, u_slave.n_mnack)
    st(8'h28, "rx held");
    for (int i = 0; i < 3; i++) begin
      rd(RX, v);
      `CHK("rx byte", 8'hc3 + 8'(i), v)
    end
    wr(ST, 8'h00);
    st(8'h00, "rx drained");
  endtask
  task automatic t_restart();
    u_slave.got.delete();
    wr(MD, 8'h80);
    wr(TX, 8'h5a);
    s = u_slave.n_start;
    p = u_slave.n_stop;
    wr(AD, 8'ha0);
    // Rewrite only once the first address byte is acknowledged
    for (int i = 0; i < 600 && !(u_slave.act && !u_slave.adr); i++)
      @(posedge clk_sys);
    wr(AD, 8'ha1);
    idle();
    `CHK("starts", s + 2, u_slave.n_start)
    `CHK("stops", p + 1, u_slave.n_stop)
    `CHK("written", 8'h5a, u_slave.got[0])
    st(8'h38, "after restart");
    rd(RX, v);
    `CHK("rx restart", 8'hc6, v)
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_write();
    t_error();
    t_read();
    t_restart();
    summarize();
  end
endmodule
